// File: rtl/aar_adv_reg.sv
// Purpose: per-port auto-negotiation advertisement register on apb
// Assumes: loader writes arrive on the system clock, straps are pins
// Notes: one wait state on every apb access
//////////////////////////////////////////////////////////////////////
// Functional notes
// - the advertisement register sits at index 4, 16 bits, read/write.
// - the serial loader overwrites it after reset release and after reload.
// - bit 13 advertises remote fault when set and resets to zero.
// - bits 11 and 10 advertise asymmetric and symmetric pause when one.
// - with port 1 in an external mode both pause bits reset to zero.
// - else manual strap low gives sym one, asym from the fd strap; high gives 0.
// - bit 8 advertises 100 full, resets 0 for external port 1, else 1.
// - bit 7 advertises 100 half duplex and always resets to one.
// - bit 6 resets 1 external, else autoneg or (not speed and duplex).
// - bit 5 resets 1 external, else autoneg or not speed.
// - bits 4:0 hold the selector and reset to the ieee 802.3 code.
// - straps are sampled when chip reset releases and held thereafter.
//
// The implementer's own choice: register access over APB.
module aar_adv_reg
    import aar_pkg::*;
(
    input wire logic clk, // system clock, 250 mhz
    input wire logic rst_n, // chip reset, async, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction, high writes
    input wire logic [11:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    input wire logic [3:0] pstrb, // apb byte strobes
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error, unmapped address
    input wire logic autonegStrap, // autoneg enable strap pin
    input wire logic speedStrap, // speed select strap pin
    input wire logic duplexStrap, // duplex select strap pin
    input wire logic manualFlowCtrlStrapPort1, // manual flow ctrl, port 1
    input wire logic manualFlowCtrlStrapPort2, // manual flow ctrl, port 2
    input wire logic fullDuplexFlowCtrlStrapPort1, // fd flow ctrl, port 1
    input wire logic fullDuplexFlowCtrlStrapPort2, // fd flow ctrl, port 2
    input wire logic portIsTwo, // this instance serves port 2
    input wire logic port1ExtMode, // port 1 uses an external mode
    input wire logic loadValid, // loader write strobe
    input wire logic [15:0] loadData, // loader write data
    output logic reloadReq, // one-cycle reload command to the loader
    output logic [15:0] advAbilities // advertised abilities to the engine
);

    //////////////////////////////////////////////////////////////////
    // strap capture

    logic [STRAP_W-1:0] strapPins;
    logic [STRAP_W-1:0] strapLatched;
    logic strapValid;

    // gather pins in the package order
    assign strapPins[S_AUTONEG] = autonegStrap;
    assign strapPins[S_SPEED] = speedStrap;
    assign strapPins[S_DUPLEX] = duplexStrap;
    assign strapPins[S_MFC1] = manualFlowCtrlStrapPort1;
    assign strapPins[S_MFC2] = manualFlowCtrlStrapPort2;
    assign strapPins[S_FDFC1] = fullDuplexFlowCtrlStrapPort1;
    assign strapPins[S_FDFC2] = fullDuplexFlowCtrlStrapPort2;
    assign strapPins[S_PORT2] = portIsTwo;
    assign strapPins[S_EXT1] = port1ExtMode;

    aar_strap_latch u_latch (
        .clk(clk),
        .rst_n(rst_n),
        .strapPins(strapPins),
        .strapLatched(strapLatched),
        .strapValid(strapValid)
    );

    //////////////////////////////////////////////////////////////////
    // default value from the held straps

    logic extMode;
    logic manFc;
    logic fdFc;
    logic an;
    logic spd;
    logic dup;
    logic [15:0] advDefault;

    // pick this port's flow control straps
    assign extMode = !strapLatched[S_PORT2] && strapLatched[S_EXT1];
    assign manFc = strapLatched[S_PORT2] ? strapLatched[S_MFC2] : strapLatched[S_MFC1];
    assign fdFc = strapLatched[S_PORT2] ? strapLatched[S_FDFC2] : strapLatched[S_FDFC1];
    assign an = strapLatched[S_AUTONEG];
    assign spd = strapLatched[S_SPEED];
    assign dup = strapLatched[S_DUPLEX];

    // reserved bits stay zero in the default word
    always_comb begin
        advDefault = '0;
        advDefault[BIT_RFAULT] = 1'b0;
        advDefault[BIT_RSVD12] = 1'b0;
        if (extMode) begin
            advDefault[BIT_ASYM] = 1'b0;
            advDefault[BIT_SYM] = 1'b0;
        end else if (!manFc) begin
            advDefault[BIT_ASYM] = fdFc;
            advDefault[BIT_SYM] = 1'b1;
        end else begin
            advDefault[BIT_ASYM] = 1'b0;
            advDefault[BIT_SYM] = 1'b0;
        end
        advDefault[BIT_FD100] = !extMode;
        advDefault[BIT_HD100] = 1'b1;
        advDefault[BIT_FD10] = extMode | an | (!spd & dup);
        advDefault[BIT_HD10] = extMode | an | !spd;
        advDefault[SEL_MSB:0] = SEL_IEEE;
    end

    //////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        aar_state_t st;
        logic [15:0] adv;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic reloadReq;
    } aar_regs_t;

    aar_regs_t q;
    aar_regs_t d;

    logic setup;
    logic done;
    logic hitAdv;
    logic hitCtrl;
    logic hitStat;
    logic defLoad;
    logic [15:0] laneMask;
    logic [15:0] swWord;

    // the access phase costs two cycles; pready rises in the second
    assign setup = psel && penable && !q.pready;
    assign done = psel && penable && q.pready;
    assign hitAdv = (paddr == ADDR_ADV);
    assign hitCtrl = (paddr == ADDR_CTRL);
    assign hitStat = (paddr == ADDR_STAT);
    assign defLoad = (q.st == ST_WAIT) && strapValid;

    // byte strobes gate the two low lanes, bits 15:14 and 9 never land
    assign laneMask = {{8{pstrb[1]}}, {8{pstrb[0]}}} & ADV_WR_MASK;
    assign swWord = (q.adv & ~laneMask) | (pwdata[15:0] & laneMask);

    //////////////////////////////////////////////////////////////////
    // next state: apb slave, default load and loader writes
    always_comb begin
        d = q;
        d.reloadReq = 1'b0;
        d.pready = 1'b0;
        // answer phase: data and error are registered on the same edge as pready
        if (setup) begin
            d.pready = 1'b1;
            d.pslverr = !(hitAdv || hitCtrl || hitStat);
            d.prdata = '0;
            if (!pwrite && hitAdv) begin
                d.prdata[15:0] = q.adv;
            end else if (!pwrite && hitStat) begin
                d.prdata[STRAP_W-1:0] = strapLatched;
                d.prdata[STAT_VALID] = strapValid;
                d.prdata[STAT_READY] = (q.st == ST_IDLE);
            end
        end
        // writes take effect on the edge that closes the transfer
        if (done && pwrite && hitAdv) begin
            d.adv = swWord;
        end
        if (done && pwrite && hitCtrl && pstrb[0]) begin
            d.reloadReq = pwdata[CTRL_RELOAD];
        end
        case (q.st)
            ST_WAIT: begin
                // straps not known yet; the default wins over any write
                if (defLoad) begin
                    d.adv = advDefault;
                    d.st = ST_IDLE;
                end
            end
            ST_IDLE: begin
                // loader has priority over a software write in one cycle
                if (loadValid) begin
                    d.adv = loadData & ADV_WR_MASK;
                end
            end
            default: begin
                d.st = ST_WAIT;
            end
        endcase
        d.adv = d.adv & ADV_WR_MASK;
    end

    // state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q.st <= ST_WAIT;
            q.adv <= ADV_RST_VAL;
            q.pready <= 1'b0;
            q.pslverr <= 1'b0;
            q.prdata <= '0;
            q.reloadReq <= 1'b0;
        end else begin
            q <= d;
        end
    end

    // outputs straight from flops
    assign prdata = q.prdata;
    assign pready = q.pready;
    assign pslverr = q.pslverr;
    assign reloadReq = q.reloadReq;
    assign advAbilities = q.adv;

    //////////////////////////////////////////////////////////////////
    // checks

    property p_rdAdv;
        @(posedge clk) disable iff (!rst_n)
        (setup && !pwrite && hitAdv) |=> (pready && prdata == {16'h0, $past(q.adv)});
    endproperty
    a_rdAdv: assert property (p_rdAdv)
        else $error("advertisement read returned wrong data");

    property p_load;
        @(posedge clk) disable iff (!rst_n)
        (q.st == ST_IDLE && loadValid) |=> (advAbilities == ($past(loadData) & ADV_WR_MASK));
    endproperty
    a_load: assert property (p_load)
        else $error("loader write not applied");

    property p_reload;
        @(posedge clk) disable iff (!rst_n)
        (done && pwrite && hitCtrl && pstrb[0] && pwdata[CTRL_RELOAD]) |=> reloadReq ##1 !reloadReq;
    endproperty
    a_reload: assert property (p_reload)
        else $error("reload pulse wrong");

    property p_rfault;
        @(posedge clk) disable iff (!rst_n)
        defLoad |=> !advAbilities[BIT_RFAULT] && !advAbilities[BIT_RSVD12];
    endproperty
    a_rfault: assert property (p_rfault)
        else $error("remote fault default not zero");

    property p_swWrite;
        @(posedge clk) disable iff (!rst_n)
        (done && pwrite && hitAdv && q.st == ST_IDLE && !loadValid && pstrb == 4'hf)
        |=> advAbilities == ($past(pwdata[15:0]) & ADV_WR_MASK);
    endproperty
    a_swWrite: assert property (p_swWrite)
        else $error("software write not stored");

    property p_extPause;
        @(posedge clk) disable iff (!rst_n)
        (defLoad && extMode) |=> advAbilities[BIT_ASYM:BIT_SYM] == 2'h0;
    endproperty
    a_extPause: assert property (p_extPause)
        else $error("external mode pause default not zero");

    property p_pause;
        @(posedge clk) disable iff (!rst_n)
        (defLoad && !extMode) |=> advAbilities[BIT_ASYM:BIT_SYM] ==
            ($past(manFc) ? 2'h0 : {$past(fdFc), 1'b1});
    endproperty
    a_pause: assert property (p_pause)
        else $error("pause default wrong");

    property p_speed100;
        @(posedge clk) disable iff (!rst_n)
        defLoad |=> advAbilities[BIT_FD100] == !$past(extMode) && advAbilities[BIT_HD100];
    endproperty
    a_speed100: assert property (p_speed100)
        else $error("100 mbit defaults wrong");

    property p_hd100;
        @(posedge clk) disable iff (!rst_n)
        defLoad |=> advAbilities[BIT_HD100] ##0 advAbilities[SEL_MSB:0] == SEL_IEEE;
    endproperty
    a_hd100: assert property (p_hd100)
        else $error("100 half duplex default not one");

    property p_fd10;
        @(posedge clk) disable iff (!rst_n)
        defLoad |=> advAbilities[BIT_FD10] ==
            ($past(extMode) | $past(an) | (!$past(spd) & $past(dup)));
    endproperty
    a_fd10: assert property (p_fd10)
        else $error("10 full duplex default wrong");

    property p_hd10;
        @(posedge clk) disable iff (!rst_n)
        defLoad |=> advAbilities[BIT_HD10] == ($past(extMode) | $past(an) | !$past(spd));
    endproperty
    a_hd10: assert property (p_hd10)
        else $error("10 half duplex default wrong");

    property p_sel;
        @(posedge clk) disable iff (!rst_n)
        defLoad |=> advAbilities[SEL_MSB:0] == SEL_IEEE;
    endproperty
    a_sel: assert property (p_sel)
        else $error("selector default wrong");

    property p_hold;
        @(posedge clk) disable iff (!rst_n)
        (strapValid && $past(strapValid)) |-> $stable(strapLatched);
    endproperty
    a_hold: assert property (p_hold)
        else $error("strap values moved after capture");

    property p_rsvd;
        @(posedge clk) disable iff (!rst_n)
        (advAbilities[15:14] == 2'h0) && !advAbilities[9];
    endproperty
    a_rsvd: assert property (p_rsvd)
        else $error("reserved bits not zero");

    property p_readyPulse;
        @(posedge clk) disable iff (!rst_n)
        pready |=> !pready;
    endproperty
    a_readyPulse: assert property (p_readyPulse)
        else $error("ready held longer than one cycle");

    property p_unmapped;
        @(posedge clk) disable iff (!rst_n)
        (setup && !(hitAdv || hitCtrl || hitStat)) |=> (pready && pslverr && prdata == 32'h0);
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped access not refused");

    property p_waitHold;
        @(posedge clk) disable iff (!rst_n)
        (q.st == ST_WAIT && !defLoad && !(done && pwrite && hitAdv)) |=> $stable(advAbilities);
    endproperty
    a_waitHold: assert property (p_waitHold)
        else $error("register moved before straps were captured");

endmodule

// File: shared/aar_pkg.sv
// Purpose: constants shared by the advertisement register block
// Assumes: apb with 32-bit data, one aligned word per register
// Notes: offsets are byte addresses on the apb
package aar_pkg;

    // register byte offsets
    localparam logic [11:0] ADDR_ADV = 12'h004;
    localparam logic [11:0] ADDR_CTRL = 12'h008;
    localparam logic [11:0] ADDR_STAT = 12'h00c;

    // advertisement field positions
    localparam int BIT_RFAULT = 13;
    localparam int BIT_RSVD12 = 12;
    localparam int BIT_ASYM = 11;
    localparam int BIT_SYM = 10;
    localparam int BIT_FD100 = 8;
    localparam int BIT_HD100 = 7;
    localparam int BIT_FD10 = 6;
    localparam int BIT_HD10 = 5;
    localparam int SEL_MSB = 4;

    // writable bits; 15:14 and 9 always read zero
    localparam logic [15:0] ADV_WR_MASK = 16'h3dff;
    // constant part of the default before straps are known
    localparam logic [15:0] ADV_RST_VAL = 16'h0081;
    localparam logic [4:0] SEL_IEEE = 5'h01;

    // control and status fields
    localparam int CTRL_RELOAD = 0;
    localparam int STAT_VALID = 9;
    localparam int STAT_READY = 10;

    // strap vector positions
    localparam int STRAP_W = 9;
    localparam int S_AUTONEG = 0;
    localparam int S_SPEED = 1;
    localparam int S_DUPLEX = 2;
    localparam int S_MFC1 = 3;
    localparam int S_MFC2 = 4;
    localparam int S_FDFC1 = 5;
    localparam int S_FDFC2 = 6;
    localparam int S_PORT2 = 7;
    localparam int S_EXT1 = 8;

    // edges the synchroniser needs before a strap sample is trusted
    localparam logic [1:0] STRAP_SETTLE = 2'h2;

    typedef enum logic [0:0] {
        ST_WAIT = 1'b0,
        ST_IDLE = 1'b1
    } aar_state_t;

endpackage

// File: rtl/aar_strap_latch.sv
// Purpose: synchronise configuration straps and capture them once
// Assumes: straps are quiet pins that settle while reset is held
// Notes: capture happens a few edges after reset release, then holds
module aar_strap_latch
    import aar_pkg::*;
(
    input wire logic clk, // system clock
    input wire logic rst_n, // chip reset, async, active low
    input wire logic [STRAP_W-1:0] strapPins, // raw strap pins
    output logic [STRAP_W-1:0] strapLatched, // held strap values
    output logic strapValid // high once captured
);

    typedef struct packed {
        logic [STRAP_W-1:0] s1;
        logic [STRAP_W-1:0] s2;
        logic [STRAP_W-1:0] held;
        logic [1:0] cnt;
        logic valid;
    } aar_latch_t;

    aar_latch_t q;
    aar_latch_t d;

    ////////////////////////////////////////////////////////////////////
    // sync chain, then a one-time capture once the chain has filled
    always_comb begin
        d = q;
        d.s1 = strapPins;
        d.s2 = q.s1;
        if (!q.valid) begin
            if (q.cnt == STRAP_SETTLE) begin
                d.held = q.s2;
                d.valid = 1'b1;
            end else begin
                d.cnt = q.cnt + 2'h1;
            end
        end
    end

    // later strap movement is ignored: held only changes before valid
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign strapLatched = q.held;
    assign strapValid = q.valid;

endmodule

// File: testbench/aar_loader_model.sv
// Purpose: behavioural serial loader that rewrites the advertisement word
// Assumes: one word per strobe on the system clock
// Notes: each burst sends a decoy word and then the image, so the last word must win
module aar_loader_model (
    input wire logic clk, // system clock
    input wire logic rst_n, // chip reset, active low
    input wire logic reloadReq, // reload pulse from the block
    input wire logic autoLoad, // burst once after reset release
    input wire logic [7:0] lag, // idle cycles before a burst
    input wire logic [15:0] image, // word to deliver
    output logic loadValid, // write strobe
    output logic [15:0] loadData // write data
);
    timeunit 1ns;
    timeprecision 100ps;

    int sinceRst;

    ////////////////////////////////////////////////////////////
    // edges since release; defaults land at the 4th, so the burst waits past it
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sinceRst <= 0;
        end else if (sinceRst < 255) begin
            sinceRst <= sinceRst + 1;
        end
    end

    ////////////////////////////////////////////////////////////
    // burst after release or reload, prompt or slow as the bench asks
    initial begin
        loadValid = 1'b0;
        loadData = 16'h0000;
        forever begin
            @(posedge clk);
            if (rst_n && (reloadReq || (autoLoad && sinceRst == 8))) begin
                repeat (lag) @(posedge clk);
                loadValid <= 1'b1;
                loadData <= ~image;
                @(posedge clk);
                loadData <= image;
                @(posedge clk);
                loadValid <= 1'b0;
                loadData <= ~image; // idle bus shows junk, not the last word
            end
        end
    end
endmodule

// File: testbench/testbench.sv
// Purpose: self-checking bench for the advertisement register block
// Assumes: apb slave answers on its own time, loader model on the far side
// Notes: all 128 combinations of the seven strap index bits are booted, index zero twice; reload runs prompt and slow
module testbench
    import aar_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic pready, pslverr, loadValid, reloadReq, err, autoLoad = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0] pstrb = 4'h0;
    logic [8:0] pins = 9'h000, p;
    logic [15:0] loadData, advAbilities, image = 16'h0000;
    logic [7:0] lag = 8'h00;
    int errTotal = 0;
    int checks = 0;
    int cycles = 0;
    int reloads = 0;

    aar_adv_reg u_aar_adv_reg (
        .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .autonegStrap(pins[0]), .speedStrap(pins[1]),
        .duplexStrap(pins[2]), .manualFlowCtrlStrapPort1(pins[3]),
        .manualFlowCtrlStrapPort2(pins[4]), .fullDuplexFlowCtrlStrapPort1(pins[5]),
        .fullDuplexFlowCtrlStrapPort2(pins[6]), .portIsTwo(pins[7]),
        .port1ExtMode(pins[8]), .loadValid(loadValid), .loadData(loadData),
        .reloadReq(reloadReq), .advAbilities(advAbilities)
    );

    aar_loader_model u_aar_loader_model (
        .clk(clk), .rst_n(rst_n), .reloadReq(reloadReq), .autoLoad(autoLoad), .lag(lag),
        .image(image), .loadValid(loadValid), .loadData(loadData)
    );

    ////////////////////////////////////////////////////////////
    // 250 mhz clock
    initial begin
        forever #2 clk = ~clk;
    end

    // hang guard and reload pulse counter
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (reloadReq === 1'b1) begin
            reloads++;
        end
        if (cycles == 20000) begin
            errTotal++;
            print_verdict();
        end
    end

    ////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks, errTotal);
        if (errTotal == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            errTotal++;
            $display("mismatch at %0t: word %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic chkFlag(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            errTotal++;
            $display("mismatch at %0t: flag %b, expected %b", $time, got, exp);
        end
    endtask

    // one apb transfer; the request holds until pready is seen at an edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
            input logic [3:0] st);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        pstrb <= st;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1); // only the hang guard ends a wait
        chk(n, 2);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk); // idle cycle keeps each strobe to one assignment per step
    endtask

    // reset with given straps, then poll until the defaults are in
    task automatic boot(input logic [8:0] s);
        int n;
        rst_n <= 1'b0;
        pins <= s;
        repeat (3) @(posedge clk);
        chk({16'h0, advAbilities}, 32'h0081); // value before straps are known
        rst_n <= 1'b1;
        n = 0;
        rd = 32'h0;
        while (rd[10] !== 1'b1 && n < 20) begin
            apb(1'b0, ADDR_STAT, 32'h0, 4'h0);
            n++;
        end
    endtask

    task automatic waitAdv(input logic [15:0] e);
        int n;
        n = 0;
        while (advAbilities !== e && n < 100) begin
            @(posedge clk);
            n++;
        end
        chk({16'h0, advAbilities}, {16'h0, e});
    endtask

    // index bits: autoneg, speed, duplex, manual fc, fd fc, port two, external
    // the unused port's flow straps take the inverse so a wrong pick shows
    function automatic logic [8:0] strapsFor(input logic [6:0] i);
        logic [8:0] s;
        s[2:0] = i[2:0];
        s[3] = i[3] ^ i[5];
        s[4] = ~s[3];
        s[5] = i[4] ^ i[5];
        s[6] = ~s[5];
        s[8:7] = i[6:5];
        return s;
    endfunction

    function automatic logic [15:0] expDefault(input logic [8:0] s);
        logic x, m, f;
        logic [15:0] v;
        x = !s[7] && s[8];
        m = s[7] ? s[4] : s[3];
        f = s[7] ? s[6] : s[5];
        v = 16'h0081;
        v[8] = !x;
        v[10] = !x && !m;
        v[11] = !x && !m && f;
        v[6] = x || s[0] || (!s[1] && s[2]);
        v[5] = x || s[0] || !s[1];
        return v;
    endfunction

    ////////////////////////////////////////////////////////////
    initial begin
        // all 128 combinations of the seven index bits; pins flip afterwards to prove they are held
        for (int i = 0; i < 128; i++) begin
            p = strapsFor(i[6:0]);
            boot(p);
            pins <= ~p;
            apb(1'b0, ADDR_STAT, 32'h0, 4'h0);
            chk(rd & 32'h7ff, {21'h0, 2'b11, p});
            apb(1'b0, ADDR_ADV, 32'h0, 4'h0);
            chk(rd, {16'h0, expDefault(p)});
            chk({16'h0, advAbilities}, {16'h0, expDefault(p)});
        end
        // walking one with upper lanes and reserved bits set; software keeps bit 12 at zero
        for (int b = 0; b < 16; b++) begin
            apb(1'b1, ADDR_ADV, (32'hffff0000 | (32'h1 << b)) & ~32'h1000, 4'hf);
            apb(1'b0, ADDR_ADV, 32'h0, 4'h0);
            chk(rd, (32'h1 << b) & 32'h2dff);
            chk({16'h0, advAbilities}, (32'h1 << b) & 32'h2dff);
        end
        // byte strobes pick the lanes written
        apb(1'b1, ADDR_ADV, 32'hefff, 4'h3);
        apb(1'b1, ADDR_ADV, 32'h0, 4'h2);
        apb(1'b0, ADDR_ADV, 32'h0, 4'h0);
        chk(rd, 32'h00ff);
        // unmapped place refuses and leaves the register alone
        apb(1'b1, 12'h010, 32'hffffffff, 4'hf);
        chkFlag(err, 1'b1);
        apb(1'b0, 12'h010, 32'h0, 4'h0);
        chkFlag(err, 1'b1);
        chk(rd, 32'h0);
        apb(1'b0, ADDR_ADV, 32'h0, 4'h0);
        chk(rd, 32'h00ff);
        // reload, prompt loader then slow loader
        image <= 16'hffff;
        apb(1'b1, ADDR_CTRL, 32'h1, 4'h1);
        waitAdv(16'h3dff);
        image <= 16'h4a5e;
        lag <= 8'd20;
        apb(1'b1, ADDR_CTRL, 32'h1, 4'h1);
        waitAdv(16'h085e);
        apb(1'b1, ADDR_CTRL, 32'h0, 4'h1);
        repeat (40) @(posedge clk);
        chk(reloads, 2);
        apb(1'b0, ADDR_CTRL, 32'h0, 4'h0);
        chk(rd, 32'h0);
        apb(1'b0, ADDR_ADV, 32'h0, 4'h0);
        chk(rd, 32'h085e);
        // loader rewrite after reset release
        autoLoad <= 1'b1;
        image <= 16'h2c63;
        lag <= 8'd3;
        boot(strapsFor(7'h00));
        waitAdv(16'h2c63);
        print_verdict();
    end
endmodule
